// ==== adc_serial_pkg.sv ====
package adc_serial_pkg;

    // Clock of the digital core
    localparam int unsigned CLOCK_PERIOD_NS      = 8;

    // Serial frame length in bits
    localparam int unsigned WORD_WIDTH           = 24;

    // Least data-ready high time, in internal master clock periods
    localparam int unsigned HIGH_TIME_BASE       = 280;
    localparam int unsigned HIGH_CNT_WIDTH       = 9;

    // Accepted master clock range in kHz, clock doubling off
    localparam int unsigned MCLK_MIN_KHZ         = 400;
    localparam int unsigned MCLK_MAX_KHZ         = 2500;
    // Accepted master clock range in kHz, clock doubling on
    localparam int unsigned MCLK_MIN_KHZ_DOUBLE  = 800;
    localparam int unsigned MCLK_MAX_KHZ_DOUBLE  = 5000;

    // Shortest period rounds up, longest period rounds down
    localparam int unsigned PERIOD_MIN_CYC =
        (1000000 / MCLK_MAX_KHZ + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned PERIOD_MAX_CYC =
        (1000000 / MCLK_MIN_KHZ) / CLOCK_PERIOD_NS;
    localparam int unsigned PERIOD_MIN_CYC_DOUBLE =
        (1000000 / MCLK_MAX_KHZ_DOUBLE + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned PERIOD_MAX_CYC_DOUBLE =
        (1000000 / MCLK_MIN_KHZ_DOUBLE) / CLOCK_PERIOD_NS;
    localparam int unsigned PERIOD_CNT_WIDTH     = 12;

    // Reset value of the serial data output
    localparam logic        DOUT_RESET           = 1'h0;

    // Serial pins coming from the host
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } serial_pins_t;

    // Clocking and modulator rate controls
    typedef struct packed {
        logic clock_double_select;
        logic modulator_rate_hi;
        logic modulator_rate_lo;
    } rate_cfg_t;

    // Frame states, Gray coded along idle, shift, done
    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'h0,
        FRAME_SHIFT = 2'h1,
        FRAME_DONE  = 2'h3
    } frame_state_t;

endpackage : adc_serial_pkg

// ==== adc_serial_port_handshake.sv ====
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_handshake #(
    parameter int unsigned WIDTH = adc_serial_pkg::WORD_WIDTH
) (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire adc_serial_pkg::serial_pins_t host_pins,          // Chip select, serial clock, data in
    input  wire logic                        sclk_idle_low,      // Host idles serial clock low
    input  wire logic                        master_clock_input, // Sampled master clock pin
    input  wire adc_serial_pkg::rate_cfg_t   rate_cfg,           // Doubling and rate bits
    input  wire logic                        result_load,        // New conversion result strobe
    input  wire logic [WIDTH-1:0]            result_data,        // New conversion result
    output logic                             dout,               // Serial data out
    output logic                             dout_oe,            // Drive enable for dout
    output logic                             data_ready_n,       // Result waiting, active low
    output logic [WIDTH-1:0]                 rx_word,            // Word written by the host
    output logic                             rx_valid,           // One-cycle strobe for rx_word
    output logic                             clock_range_fault   // Master clock out of range
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Least high time in internal ticks for the selected modulator rate
    function automatic logic [adc_serial_pkg::HIGH_CNT_WIDTH-1:0] high_time_ticks(
        input logic hi,
        input logic lo
    );
        logic [1:0] shift;
        // Exponent of N is twice the high bit plus the low bit
        shift = {hi, lo};
        return adc_serial_pkg::HIGH_CNT_WIDTH'(adc_serial_pkg::HIGH_TIME_BASE >> shift);
    endfunction : high_time_ticks

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock: edge detect, divider, range check, start-up

    logic                                        mclk_q;        // Last sample of master clock
    logic                                        master_div;    // Divide-by-two phase
    logic                                        started;       // First master edge seen
    logic [adc_serial_pkg::PERIOD_CNT_WIDTH-1:0] period_cnt;    // Core cycles since master edge
    logic                                        next_master_div;
    logic                                        next_started;
    logic [adc_serial_pkg::PERIOD_CNT_WIDTH-1:0] next_period_cnt;
    logic                                        next_fault;
    logic                                        master_edge;   // Rising master clock edge
    logic                                        tick;          // Internal master clock tick

    // Doubling halves the pin rate so the timing of everything else holds
    always_comb begin
        logic [adc_serial_pkg::PERIOD_CNT_WIDTH-1:0] pmin;
        logic [adc_serial_pkg::PERIOD_CNT_WIDTH-1:0] pmax;
        pmin            = rate_cfg.clock_double_select
                        ? adc_serial_pkg::PERIOD_CNT_WIDTH'(adc_serial_pkg::PERIOD_MIN_CYC_DOUBLE)
                        : adc_serial_pkg::PERIOD_CNT_WIDTH'(adc_serial_pkg::PERIOD_MIN_CYC);
        pmax            = rate_cfg.clock_double_select
                        ? adc_serial_pkg::PERIOD_CNT_WIDTH'(adc_serial_pkg::PERIOD_MAX_CYC_DOUBLE)
                        : adc_serial_pkg::PERIOD_CNT_WIDTH'(adc_serial_pkg::PERIOD_MAX_CYC);
        master_edge     = master_clock_input && !mclk_q;
        next_master_div = master_div;
        next_started    = started || master_edge;
        next_fault      = clock_range_fault;
        next_period_cnt = period_cnt;
        tick            = 1'h0;
        if (master_edge) begin
            // Only every other pin edge counts when doubling is on
            next_master_div = rate_cfg.clock_double_select ? !master_div : 1'h0;
            tick            = !rate_cfg.clock_double_select || master_div;
            next_period_cnt = '0;
            // A stopped clock in standby is legal, so only judge on edges
            if (started) begin
                next_fault = (period_cnt < pmin) || (period_cnt > pmax);
            end
        end else if (period_cnt != '1) begin
            next_period_cnt = period_cnt + 1'h1;
        end
    end

    // Master clock registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Starts high so a pin already high at release is not a false edge
            mclk_q            <= 1'h1;
            master_div        <= 1'h0;
            started           <= 1'h0;
            period_cnt        <= '0;
            clock_range_fault <= 1'h0;
        end else begin
            mclk_q            <= master_clock_input;
            master_div        <= next_master_div;
            started           <= next_started;
            period_cnt        <= next_period_cnt;
            clock_range_fault <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame: launch on falling, sample on rising

    adc_serial_pkg::frame_state_t state;          // Frame state
    adc_serial_pkg::frame_state_t next_state;
    logic                         sclk_q;         // Last sample of serial clock
    logic [WIDTH-1:0]             tx_shift;       // Outgoing bits, MSB first
    logic [WIDTH-1:0]             rx_shift;       // Incoming bits
    logic [$clog2(WIDTH)-1:0]     bit_cnt;        // Bits sampled in this word
    logic [WIDTH-1:0]             next_tx_shift;
    logic [WIDTH-1:0]             next_rx_shift;
    logic [$clog2(WIDTH)-1:0]     next_bit_cnt;
    logic                         next_dout;
    logic                         next_dout_oe;
    logic [WIDTH-1:0]             next_rx_word;
    logic                         next_rx_valid;
    logic                         launch_edge;    // Active falling edge
    logic                         sample_edge;    // Active rising edge
    logic                         read_done;      // Last bit of a word sampled
    logic [WIDTH-1:0]             out_data;       // Output data register

    // Low idle simply inverts the clock, which swaps the edge roles
    always_comb begin
        logic sclk_now;
        logic sclk_was;
        sclk_now      = host_pins.sclk ^ sclk_idle_low;
        sclk_was      = sclk_q ^ sclk_idle_low;
        launch_edge   = started && !host_pins.cs_n && sclk_was && !sclk_now;
        sample_edge   = started && !host_pins.cs_n && !sclk_was && sclk_now;
        read_done     = 1'h0;
        next_state    = state;
        next_tx_shift = tx_shift;
        next_rx_shift = rx_shift;
        next_bit_cnt  = bit_cnt;
        next_dout     = dout;
        next_dout_oe  = dout_oe;
        next_rx_word  = rx_word;
        next_rx_valid = 1'h0;
        if (!started || host_pins.cs_n) begin
            // Deselected: let go of the shared line
            next_state   = adc_serial_pkg::FRAME_IDLE;
            next_dout_oe = 1'h0;
        end else begin
            case (state)
                adc_serial_pkg::FRAME_IDLE: begin
                    next_state    = adc_serial_pkg::FRAME_SHIFT;
                    next_tx_shift = out_data;
                    next_bit_cnt  = '0;
                end
                adc_serial_pkg::FRAME_SHIFT: begin
                    if (launch_edge) begin
                        next_dout     = tx_shift[WIDTH-1];
                        next_dout_oe  = 1'h1;
                        next_tx_shift = tx_shift << 1;
                    end
                    if (sample_edge) begin
                        next_rx_shift = {rx_shift[WIDTH-2:0], host_pins.din};
                        next_bit_cnt  = bit_cnt + 1'h1;
                        if (bit_cnt == ($clog2(WIDTH))'(WIDTH - 1)) begin
                            read_done     = 1'h1;
                            next_dout_oe  = 1'h0;
                            next_rx_word  = {rx_shift[WIDTH-2:0], host_pins.din};
                            next_rx_valid = 1'h1;
                            next_state    = adc_serial_pkg::FRAME_DONE;
                        end
                    end
                end
                adc_serial_pkg::FRAME_DONE: begin
                    // Tied-low chip select: next falling edge starts a new word
                    if (launch_edge) begin
                        next_dout     = out_data[WIDTH-1];
                        next_dout_oe  = 1'h1;
                        next_tx_shift = out_data << 1;
                        next_bit_cnt  = '0;
                        next_state    = adc_serial_pkg::FRAME_SHIFT;
                    end
                end
                default: begin
                    next_state = adc_serial_pkg::FRAME_IDLE;
                end
            endcase
        end
    end

    // Serial frame registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= adc_serial_pkg::FRAME_IDLE;
            sclk_q   <= 1'h1;
            tx_shift <= '0;
            rx_shift <= '0;
            bit_cnt  <= '0;
            dout     <= adc_serial_pkg::DOUT_RESET;
            dout_oe  <= 1'h0;
            rx_word  <= '0;
            rx_valid <= 1'h0;
        end else begin
            state    <= next_state;
            sclk_q   <= host_pins.sclk;
            tx_shift <= next_tx_shift;
            rx_shift <= next_rx_shift;
            bit_cnt  <= next_bit_cnt;
            dout     <= next_dout;
            dout_oe  <= next_dout_oe;
            rx_word  <= next_rx_word;
            rx_valid <= next_rx_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data-ready handshake and output data register

    logic                                      pending;      // Result waiting to be loaded
    logic [WIDTH-1:0]                          pend_data;    // The waiting result
    logic [adc_serial_pkg::HIGH_CNT_WIDTH-1:0] high_cnt;     // Ticks spent with ready high
    logic                                      next_pending;
    logic [WIDTH-1:0]                          next_pend_data;
    logic [WIDTH-1:0]                          next_out_data;
    logic                                      next_ready_n;
    logic [adc_serial_pkg::HIGH_CNT_WIDTH-1:0] next_high_cnt;
    logic                                      high_time_met;

    // Never swap the output word mid-word, so a reread stays coherent
    always_comb begin
        // One tick more than the minimum, since the first tick may land right after the rise
        high_time_met  = high_cnt > high_time_ticks(rate_cfg.modulator_rate_hi,
                                                     rate_cfg.modulator_rate_lo);
        next_pending   = pending;
        next_pend_data = pend_data;
        next_out_data  = out_data;
        next_ready_n   = data_ready_n;
        next_high_cnt  = high_cnt;
        if (data_ready_n && tick && high_cnt != '1) begin
            next_high_cnt = high_cnt + 1'h1;
        end
        if (!data_ready_n && read_done) begin
            next_ready_n  = 1'h1;
            next_high_cnt = '0;
        end else if (pending && state != adc_serial_pkg::FRAME_SHIFT) begin
            if (!data_ready_n) begin
                // Unread result about to be replaced: open the high gap first
                next_ready_n  = 1'h1;
                next_high_cnt = '0;
            end else if (high_time_met) begin
                next_out_data = pend_data;
                next_ready_n  = 1'h0;
                next_pending  = 1'h0;
                next_high_cnt = '0;
            end
        end
        // A new result arriving as the old one is taken is kept
        if (result_load && started) begin
            next_pending   = 1'h1;
            next_pend_data = result_data;
        end
    end

    // Handshake registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending      <= 1'h0;
            pend_data    <= '0;
            out_data     <= '0;
            data_ready_n <= 1'h1;
            high_cnt     <= '0;
        end else begin
            pending      <= next_pending;
            pend_data    <= next_pend_data;
            out_data     <= next_out_data;
            data_ready_n <= next_ready_n;
            high_cnt     <= next_high_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_launch_on_fall: assert property ($changed(dout) |-> $past(launch_edge))
        else $error("dout changed outside a launch edge");
    a_sample_on_rise: assert property (rx_valid |-> $past(sample_edge) && $past(read_done))
        else $error("word completed without a sample edge");
    a_release_after: assert property (read_done |=> !dout_oe)
        else $error("dout still driven after last rising edge");
    a_ready_cleared: assert property (read_done && !data_ready_n |=> data_ready_n)
        else $error("data ready not raised by completed read");
    a_ready_loads: assert property ($fell(data_ready_n) |-> out_data == $past(pend_data))
        else $error("data ready fell without loading result");
    a_high_time: assert property ($fell(data_ready_n) |-> $past(high_time_met))
        else $error("data ready high time too short");
    a_double_div: assert property (tick && rate_cfg.clock_double_select |-> master_div)
        else $error("doubled master clock not divided");
    a_reset_quiet: assert property (!started |-> data_ready_n && !dout_oe && !rx_valid)
        else $error("activity before master clock started");

endmodule : adc_serial_port_handshake

`default_nettype wire

// ==== host_serial_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host controller as serial master; edge roles follow the chosen idle level
module host_serial_model #(
    parameter int unsigned W = adc_serial_pkg::WORD_WIDTH
) (
    input  wire logic                         clock,
    input  wire logic                         sclk_idle_low, // Low idle only with select toggled
    input  wire logic                         dout_line,     // Resolved data line from the device
    output var  adc_serial_pkg::serial_pins_t pins           // Select, serial clock, data in
);
    ////////////////////////////////////////////////////////////////////////////
    // Park all lines: select off, clock at its idle level
    task automatic park();
        pins.cs_n = 1'h1;
        pins.sclk = ~sclk_idle_low; // Idle level of the serial clock
        pins.din  = 1'h0;
    endtask : park

    ////////////////////////////////////////////////////////////////////////////
    // One frame; fewer than W bits aborts it, keep_cs leaves select low after
    // Phases of four core cycles keep well clear of the two-cycle minimum
    task automatic xfer(input logic [W-1:0] tx, input int nbits, input bit keep_cs,
                        output logic [W-1:0] rx);
        int i;
        rx = '0;
        @(posedge clock);
        #1 pins.cs_n = 1'h0; // Select driven low at the start of each access
        repeat (4) @(posedge clock);
        for (i = 0; i < nbits; i++) begin
            #1 pins.sclk = sclk_idle_low; // Launch edge, swapped under low idle
            pins.din = tx[W-1-i];         // Data set well before the sampling edge
            repeat (4) @(posedge clock);
            #1 pins.sclk = ~sclk_idle_low; // Sampling edge
            rx = {rx[W-2:0], dout_line};   // Capture on the edge after the launch
            repeat (4) @(posedge clock);
        end
        if (!keep_cs) begin
            #1 pins.cs_n = 1'h1;
        end
    endtask : xfer

    // Lines idle from time zero
    initial begin
        park();
    end
endmodule : host_serial_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    localparam int W = adc_serial_pkg::WORD_WIDTH;

    logic                         clock;             // Core clock
    logic                         rst_n;             // Reset, active low
    adc_serial_pkg::serial_pins_t host_pins;         // Driven by the host model
    logic                         sclk_idle_low;     // Serial clock idle choice
    logic                         mck;               // Master clock pin
    adc_serial_pkg::rate_cfg_t    rate_cfg;          // Doubling and rate bits
    logic                         result_load;       // New result strobe
    logic [W-1:0]                 result_data;       // New result word
    logic                         dout;              // Device data out
    logic                         dout_oe;           // Device drive enable
    logic                         dout_line;         // Resolved data line
    logic                         last_dout = 1'h0;  // Last level the device drove
    logic                         data_ready_n;      // Result waiting, active low
    logic [W-1:0]                 rx_word;           // Word the host wrote
    logic                         rx_valid;          // Strobe with rx_word
    logic                         clock_range_fault; // Master clock out of range
    int                           mhalf = 32;        // Master half period, core cycles
    int                           num_errors;        // Mismatches seen
    int                           num_checks;        // Comparisons made
    int                           nvalid;            // Words received so far
    int                           hcnt;              // Cycles since data ready rose
    int                           min_high;          // Least high span for current rates
    int                           r;                 // Row of the setting table
    int                           n0;                // Word count at row start
    logic                         prev_rdy;          // Data ready one cycle ago
    integer                       seed;              // Random seed
    logic [31:0]                  rnd;               // Random draw
    logic [W-1:0]                 exp_res;           // Model: newest result
    logic [W-1:0]                 tx;                // Word sent by the host
    logic [W-1:0]                 rx;                // Word read by the host
    logic [3:0]                   cfg_tab [5];       // Double, rate hi, rate lo, idle low

    adc_serial_port_handshake #(.WIDTH(W)) dut (
        .clock(clock), .rst_n(rst_n), .host_pins(host_pins), .sclk_idle_low(sclk_idle_low),
        .master_clock_input(mck), .rate_cfg(rate_cfg), .result_load(result_load),
        .result_data(result_data), .dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n),
        .rx_word(rx_word), .rx_valid(rx_valid), .clock_range_fault(clock_range_fault));

    host_serial_model #(.W(W)) host (
        .clock(clock), .sclk_idle_low(sclk_idle_low), .dout_line(dout_line), .pins(host_pins));

    ////////////////////////////////////////////////////////////////////////////
    // No pull on the line: once released it shows the inverse of the last level
    assign dout_line = dout_oe ? dout : ~last_dout;
    always @(posedge clock) begin
        if (dout_oe) begin
            last_dout <= dout;
        end
    end

    // Core clock, 8 ns period
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // Master clock never stops outside standby
    initial begin
        mck = 1'h0;
        forever begin
            repeat (mhalf) @(posedge clock);
            #1 mck = ~mck;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count; mismatch reported at once
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // Reset with static settings applied while held
    task automatic apply_reset(input logic [3:0] c);
        rst_n = 1'h0;
        result_load = 1'h0;
        rate_cfg = c[3:1];
        sclk_idle_low = c[0];
        host.park();
        min_high = (adc_serial_pkg::HIGH_TIME_BASE >> (2 * c[2] + c[1])) * 2 * mhalf * (c[3] ? 2 : 1);
        repeat (6) @(posedge clock);
        #1 check({dout_oe, data_ready_n, rx_valid, clock_range_fault}, 4'h4);
        check(rx_word, 0);
        rst_n = 1'h1;
        repeat (6 * mhalf) @(posedge clock); // Leave time for master edges to start it
        #1;
    endtask : apply_reset

    // Fresh random result into the device and the model
    task automatic load_result();
        @(posedge clock);
        #1 result_load = 1'h1;
        rnd = $random(seed);
        result_data = rnd[W-1:0];
        exp_res = rnd[W-1:0];
        @(posedge clock);
        #1 result_load = 1'h0;
    endtask : load_result

    // Bounded wait for data ready to fall
    task automatic wait_ready();
        int k;
        for (k = 0; k < (2 * adc_serial_pkg::HIGH_TIME_BASE + 8) * 4 * mhalf && data_ready_n !== 1'h0; k++) begin
            @(posedge clock);
            #1;
        end
        check(data_ready_n, 0);
    endtask : wait_ready

    // Host frame with a random write word
    task automatic frame(input int nbits, input bit keep_cs);
        rnd = $random(seed);
        tx = rnd[W-1:0];
        host.xfer(tx, nbits, keep_cs, rx);
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////
    // High span monitor and word counter, sampled away from the active edge
    always @(negedge clock) begin
        if (rst_n === 1'h1 && prev_rdy === 1'h1 && data_ready_n === 1'h0) begin
            check(hcnt >= min_high, 1);
        end
        hcnt = (data_ready_n === 1'h1 && rst_n === 1'h1) ? hcnt + 1 : 0;
        prev_rdy = data_ready_n;
        if (rx_valid === 1'h1) begin
            nvalid++;
        end
    end

    // Watchdog: longest row waits about 18k cycles, whole run about 50k
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence over every rate setting, both idle levels and doubling
    initial begin
        seed = 32'h7a99;
        num_errors = 0;
        num_checks = 0;
        nvalid = 0;
        hcnt = 0;
        rst_n = 1'h0;
        result_load = 1'h0;
        result_data = '0;
        rate_cfg = '0;
        sclk_idle_low = 1'h0;
        cfg_tab = '{4'h0, 4'h3, 4'h4, 4'h7, 4'he};
        for (r = 0; r < 5; r++) begin
            apply_reset(cfg_tab[r]);
            check(clock_range_fault, 0);
            load_result();
            wait_ready();
            n0 = nvalid;
            frame(W, 0);
            check(rx, exp_res);
            check(rx_word, tx);
            check(nvalid, n0 + 1);
            check(dout_oe, 0);
            check(data_ready_n, 1);
            frame(W, !cfg_tab[r][0]); // Select held low only with high idle
            check(rx, exp_res);
            frame(8, 0); // Aborted word
            repeat (2) @(posedge clock);
            #1 check(dout_oe, 0);
            check(nvalid, n0 + 2);
        end
        // Sixth reset while a result is waiting
        load_result();
        wait_ready();
        apply_reset(4'h6); // Checks reset values mid-run
        // Master clock too fast, too slow, then back in range
        mhalf = 8;
        repeat (200) @(posedge clock);
        #1 check(clock_range_fault, 1);
        mhalf = 200;
        repeat (1600) @(posedge clock);
        #1 check(clock_range_fault, 1);
        mhalf = 32;
        repeat (400) @(posedge clock);
        #1 check(clock_range_fault, 0);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
